// [rtl/cgu_pkg.sv]
// cgu_pkg: constants and types for the clock generation unit
// assumes one reference clock at 250 MHz, synchronous active-low reset
package cgu_pkg;
    // ==========================================
    // clock rate and monitor timing
    localparam int REF_CLK_MHZ = 250;
    localparam int MON_MIN_NS = 2000;
    localparam int MON_MAX_NS = 20000;
    localparam int MON_MIN_CYC = (MON_MIN_NS * REF_CLK_MHZ + 999) / 1000;
    // width of the reference divider whose top bit the monitor watches
    localparam int MON_DIV_W = 5;
    // ==========================================
    // watchdog service values
    localparam logic [7:0] SVC_FIRST = 8'h55;
    localparam logic [7:0] SVC_SECOND = 8'haa;
    // ==========================================
    // dividers
    localparam int PRE_DIV_LOG2 = 13;
    localparam int RTI_BASE_LOG2 = 13;
    localparam int SLOW_MAX_LOG2 = 7;
    localparam int WD_CNT_W = 7;
    localparam int RTI_CNT_W = 20;
    localparam logic [2:0] RATE_OFF = 3'h0;
    // reset values of control fields
    localparam logic [2:0] SLOW_RST = 3'h0;
    localparam logic [2:0] WD_RATE_RST = 3'h0;
    localparam logic [2:0] RTI_RATE_RST = 3'h0;
    localparam logic MON_EN_RST = 1'b0;
    localparam logic RTI_IE_RST = 1'b0;

    typedef enum logic [1:0] {
        WD_IDLE,
        WD_ARMED
    } cgu_wd_state_t;
endpackage

// [rtl/cgu_tick_if.sv]
// cgu_tick_if: timebase strobes shared between the top and its leaves
// assumes all strobes are one-cycle pulses on i_ref_clk
`timescale 1ns/10ps
interface cgu_tick_if;
    logic e_tick;
    logic pre_tick;
    logic [19:0] e_count;
    modport src (output e_tick, output pre_tick, output e_count);
    modport dst (input e_tick, input pre_tick, input e_count);
endinterface

// [rtl/cgu_watchdog.sv]
// cgu_watchdog: service-sequence watchdog counting the prescaled tick
// assumes service writes are one-cycle strobes with data
`timescale 1ns/10ps
module cgu_watchdog
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    cgu_tick_if.dst tick,
    input wire logic [2:0] i_rate,
    input wire logic i_svc_wr,
    input wire logic [7:0] i_svc_data,
    output logic o_timeout,
    output logic o_bad_write
);
    cgu_pkg::cgu_wd_state_t state_ff;
    cgu_pkg::cgu_wd_state_t nxt_state;
    logic [cgu_pkg::WD_CNT_W-1:0] cnt_ff;
    logic tout_ff;
    logic bad_ff;

    // ==========================================
    // decode
    wire enabled = (i_rate != cgu_pkg::RATE_OFF);
    wire is_first = i_svc_data == cgu_pkg::SVC_FIRST;
    wire is_second = i_svc_data == cgu_pkg::SVC_SECOND;
    wire serviced = i_svc_wr && is_second && state_ff == cgu_pkg::WD_ARMED;
    // terminal count for 2^(rate-1) prescaled ticks
    wire [cgu_pkg::WD_CNT_W-1:0] last = 7'((8'h1 << (i_rate - 3'h1)) - 8'h1);
    wire expire = enabled && tick.pre_tick && cnt_ff == last;

    always_comb
    begin
        nxt_state = state_ff;
        if (i_svc_wr && is_first)
            nxt_state = cgu_pkg::WD_ARMED;
        else if (i_svc_wr && is_second)
            nxt_state = cgu_pkg::WD_IDLE;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            state_ff <= cgu_pkg::WD_IDLE;
            cnt_ff <= '0;
            tout_ff <= 1'b0;
            bad_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (!enabled || serviced)
                cnt_ff <= '0;
            else if (tick.pre_tick)
                cnt_ff <= expire ? '0 : cnt_ff + 7'h1;
            tout_ff <= expire;
            bad_ff <= i_svc_wr && !is_first && !is_second;
        end
    end

    assign o_timeout = tout_ff;
    assign o_bad_write = bad_ff;
endmodule

// [rtl/cgu_clock_monitor.sv]
// cgu_clock_monitor: stall detector with its own free-running delay line
// assumes i_mon_osc is a slow on-chip RC oscillator, independent of i_ref_clk
`timescale 1ns/10ps
module cgu_clock_monitor
(
    input wire logic i_mon_osc,
    input wire logic i_ref_toggle,
    input wire logic i_enable,
    output logic o_stall
);
    // edge detect of the reference toggle in the RC domain; no reset needed,
    // the count settles within a few RC periods
    logic sync1_ff = 1'b0;
    logic sync2_ff = 1'b0;
    logic prev_ff = 1'b0;
    logic [3:0] idle_ff = 4'h0;
    logic stall_ff = 1'b0;

    wire edge_seen = sync2_ff ^ prev_ff;

    always_ff @(posedge i_mon_osc)
    begin
        sync1_ff <= i_ref_toggle;
        sync2_ff <= sync1_ff;
        prev_ff <= sync2_ff;
        if (edge_seen || !i_enable)
            idle_ff <= 4'h0;
        else if (idle_ff != 4'hf)
            idle_ff <= idle_ff + 4'h1;
        stall_ff <= i_enable && idle_ff == 4'hf;
    end

    assign o_stall = stall_ff;
endmodule

// [rtl/cgu_top.sv]
// cgu_top: clock generation unit with slow divider, periodic interrupt,
// watchdog and clock-stall monitor
// assumes i_ref_clk is the oscillator; clock outputs are enable-style levels
`timescale 1ns/10ps
// Notes on behaviour
// - make peripheral, bus and four phase clocks
// - slowed pair feeds peripherals in wait mode
// - fixed pair stays oscillator/2 and /4 for link, timer
// - slow divider divides by powers of two, max 128
// - zero select or not waiting bypasses divider
// - stall monitor watches oscillator divided by 32
// - enabled watchdog times out into reset
// - three-bit watchdog rate, seven periods or off
// - service 0x55 then 0xaa each period
// - other service value resets immediately
// - periodic interrupt: seven rates, flag, enable
// - stall beyond RC delay raises reset
// - monitor enable bit gates the stall monitor
// - slow divisor is two to the select
// - periodic rate 2^13 to 2^19 of bus
// - flag cleared by writing one
// - watchdog counts bus/2^13 scaled by rate
module cgu_top
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_mon_osc,
    input wire logic i_wait_mode,
    input wire logic [2:0] i_slow_divisor_select,
    input wire logic [2:0] i_periodic_rate_select,
    input wire logic i_periodic_irq_enable,
    input wire logic i_periodic_flag_wr,
    input wire logic i_periodic_flag_wdata,
    input wire logic [2:0] i_watchdog_rate_select,
    input wire logic i_monitor_enable_bit,
    input wire logic i_watchdog_service_wr,
    input wire logic [7:0] i_watchdog_service_data,
    output logic o_p_clk,
    output logic o_e_clk,
    output logic o_fixed_p_clk,
    output logic o_fixed_e_clk,
    output logic [3:0] o_phase_clk,
    output logic o_periodic_timeout_flag,
    output logic o_periodic_irq,
    output logic o_watchdog_reset,
    output logic o_monitor_reset
);
    // ==========================================
    // fixed oscillator/2 and /4 pair and phases
    logic [1:0] phase_ff;
    logic [2:0] slow_sel_ff;
    logic [cgu_pkg::SLOW_MAX_LOG2-1:0] slow_cnt_ff;
    logic slow_p_ff;
    logic slow_e_ff;
    logic fixed_p_ff;
    logic fixed_e_ff;
    logic [3:0] phase_clk_ff;
    logic [cgu_pkg::RTI_CNT_W-1:0] e_cnt_ff;
    logic e_tick_ff;
    logic flag_ff;
    logic irq_ff;
    logic wd_rst_ff;
    logic mon_rst_ff;
    logic [cgu_pkg::MON_DIV_W-1:0] ref_div_ff;

    cgu_tick_if tick ();

    // one bus cycle is four oscillator cycles; four phases over that cycle
    wire [1:0] nxt_phase = phase_ff + 2'h1;
    wire e_edge = phase_ff == 2'h3;

    // ==========================================
    // slow divider
    wire slow_on = i_wait_mode && slow_sel_ff != 3'h0;
    // bus period doubles per select step: 2^sel bus cycles per slowed cycle
    wire [cgu_pkg::SLOW_MAX_LOG2-1:0] slow_last =
        7'((8'h1 << slow_sel_ff) - 8'h1);
    wire slow_wrap = slow_cnt_ff == slow_last;
    wire slow_tick = e_edge && (!slow_on || slow_wrap);

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            phase_ff <= 2'h0;
            slow_sel_ff <= cgu_pkg::SLOW_RST;
            slow_cnt_ff <= '0;
            fixed_p_ff <= 1'b0;
            fixed_e_ff <= 1'b0;
            phase_clk_ff <= 4'h1;
        end
        else
        begin
            phase_ff <= nxt_phase;
            // select only changes on a slowed-cycle boundary to avoid runts
            if (slow_tick)
                slow_sel_ff <= i_slow_divisor_select;
            if (e_edge)
                slow_cnt_ff <= (slow_on && !slow_wrap) ? slow_cnt_ff + 7'h1 : '0;
            fixed_p_ff <= ~phase_ff[0];
            fixed_e_ff <= phase_ff[1];
            phase_clk_ff <= {phase_clk_ff[2:0], phase_clk_ff[3]};
        end
    end

    // slowed pair: during the last bus cycle of each slowed period
    wire slow_window = !slow_on || slow_wrap;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            slow_p_ff <= 1'b0;
            slow_e_ff <= 1'b0;
        end
        else
        begin
            slow_p_ff <= slow_window ? ~phase_ff[0] : 1'b0;
            slow_e_ff <= slow_window ? phase_ff[1] : 1'b0;
        end
    end

    // ==========================================
    // bus-cycle timebase for periodic interrupt and watchdog
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            e_cnt_ff <= '0;
            e_tick_ff <= 1'b0;
        end
        else
        begin
            e_tick_ff <= slow_tick;
            if (slow_tick)
                e_cnt_ff <= e_cnt_ff + 20'h1;
        end
    end

    // count wraps to zero on the tick that marks a 2^n boundary
    function automatic logic boundary(input logic [cgu_pkg::RTI_CNT_W-1:0] cnt,
                                      input int log2);
        logic [cgu_pkg::RTI_CNT_W-1:0] mask;
        mask = 20'((21'h1 << log2) - 21'h1);
        boundary = (cnt & mask) == '0;
    endfunction

    assign tick.e_tick = e_tick_ff;
    assign tick.e_count = e_cnt_ff;
    assign tick.pre_tick = e_tick_ff && boundary(e_cnt_ff, cgu_pkg::PRE_DIV_LOG2);

    // ==========================================
    // periodic interrupt
    wire rti_on = i_periodic_rate_select != cgu_pkg::RATE_OFF;
    wire [4:0] rti_log2 = 5'(cgu_pkg::RTI_BASE_LOG2) + 5'(i_periodic_rate_select) - 5'h1;
    wire rti_hit = rti_on && e_tick_ff && boundary(e_cnt_ff, int'(rti_log2));
    wire flag_clr = i_periodic_flag_wr && i_periodic_flag_wdata;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            flag_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            // a timeout in the clearing cycle wins
            flag_ff <= rti_hit | (flag_ff & ~flag_clr);
            irq_ff <= (rti_hit | (flag_ff & ~flag_clr)) & i_periodic_irq_enable;
        end
    end

    // ==========================================
    // watchdog
    logic wd_timeout;
    logic wd_bad;

    cgu_watchdog u_watchdog
    (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .tick(tick.dst),
        .i_rate(i_watchdog_rate_select),
        .i_svc_wr(i_watchdog_service_wr),
        .i_svc_data(i_watchdog_service_data),
        .o_timeout(wd_timeout),
        .o_bad_write(wd_bad)
    );

    // ==========================================
    // clock-stall monitor
    logic mon_stall;
    logic mon_s1_ff;
    logic mon_s2_ff;

    cgu_clock_monitor u_monitor
    (
        .i_mon_osc(i_mon_osc),
        .i_ref_toggle(ref_div_ff[cgu_pkg::MON_DIV_W-1]),
        .i_enable(i_monitor_enable_bit),
        .o_stall(mon_stall)
    );

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            ref_div_ff <= '0;
            wd_rst_ff <= 1'b0;
            mon_s1_ff <= 1'b0;
            mon_s2_ff <= 1'b0;
            mon_rst_ff <= 1'b0;
        end
        else
        begin
            // a per-cycle toggle aliases in the slow RC domain; a divided
            // bit holds each level longer than one monitor clock period
            ref_div_ff <= ref_div_ff + 5'h1;
            wd_rst_ff <= wd_timeout | wd_bad;
            mon_s1_ff <= mon_stall;
            mon_s2_ff <= mon_s1_ff;
            mon_rst_ff <= mon_s2_ff;
        end
    end

    // raw stall level goes straight out: the reference may be dead
    assign o_monitor_reset = mon_stall | mon_rst_ff;
    assign o_p_clk = slow_p_ff;
    assign o_e_clk = slow_e_ff;
    assign o_fixed_p_clk = fixed_p_ff;
    assign o_fixed_e_clk = fixed_e_ff;
    assign o_phase_clk = phase_clk_ff;
    assign o_periodic_timeout_flag = flag_ff;
    assign o_periodic_irq = irq_ff;
    assign o_watchdog_reset = wd_rst_ff;
endmodule

// [verif/cgu_top_props.sv]
// cgu_top_props: port-level checks of the clock generation unit
// assumes one reference clock and a synchronous active-low reset
`timescale 1ns/10ps
module cgu_top_props
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_wait_mode,
    input wire logic [2:0] i_periodic_rate_select,
    input wire logic i_periodic_irq_enable,
    input wire logic [2:0] i_watchdog_rate_select,
    input wire logic i_watchdog_service_wr,
    input wire logic [7:0] i_watchdog_service_data,
    input wire logic o_fixed_p_clk,
    input wire logic [3:0] o_phase_clk,
    input wire logic o_periodic_timeout_flag,
    input wire logic o_periodic_irq,
    input wire logic o_watchdog_reset
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);
    // ==========================================
    // watchdog
    sequence s_bad_write;
        i_watchdog_service_wr && i_watchdog_service_data != cgu_pkg::SVC_FIRST
            && i_watchdog_service_data != cgu_pkg::SVC_SECOND;
    endsequence
    sequence s_rst_late;
        ##2 o_watchdog_reset;
    endsequence
    a_bad_value_rst: assert property (s_bad_write |-> s_rst_late)
        else $error("no reset after bad service value");
    a_arm_no_rst: assert property (i_watchdog_service_wr
        && i_watchdog_service_data == cgu_pkg::SVC_FIRST |-> ##2 !o_watchdog_reset)
        else $error("reset after arming value");
    a_wd_off_quiet: assert property ((i_watchdog_rate_select == 3'h0
        && !i_watchdog_service_wr) [*3] |=> !o_watchdog_reset)
        else $error("reset while watchdog off");
    a_rst_one_cycle: assert property (o_watchdog_reset
        |=> !o_watchdog_reset || $past(i_watchdog_service_wr, 2))
        else $error("watchdog reset too long");
    // ==========================================
    // periodic interrupt and clocks
    a_rate_off_idle: assert property (i_periodic_rate_select == 3'h0
        && $past(i_periodic_rate_select) == 3'h0 && !o_periodic_timeout_flag
        |=> !o_periodic_timeout_flag)
        else $error("flag set while periodic off");
    a_irq_flag_en: assert property (o_periodic_irq
        == (o_periodic_timeout_flag && $past(i_periodic_irq_enable)))
        else $error("irq not flag and enable");
    a_fixed_half: assert property ($past(i_reset_n, 2)
        |-> o_fixed_p_clk != $past(o_fixed_p_clk))
        else $error("fixed clock not at half rate");
    a_phase_onehot: assert property ($onehot(o_phase_clk))
        else $error("phase clocks not one-hot");
endmodule
bind cgu_top cgu_top_props u_props
(
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_wait_mode(i_wait_mode),
    .i_periodic_rate_select(i_periodic_rate_select),
    .i_periodic_irq_enable(i_periodic_irq_enable),
    .i_watchdog_rate_select(i_watchdog_rate_select),
    .i_watchdog_service_wr(i_watchdog_service_wr),
    .i_watchdog_service_data(i_watchdog_service_data), .o_fixed_p_clk(o_fixed_p_clk),
    .o_phase_clk(o_phase_clk), .o_periodic_timeout_flag(o_periodic_timeout_flag),
    .o_periodic_irq(o_periodic_irq), .o_watchdog_reset(o_watchdog_reset)
);

// [verif/cgu_cpu_model.sv]
// cgu_cpu_model: processor side writing the watchdog service register
// assumes the bench asks for a write with a one-cycle i_go strobe
`timescale 1ns/10ps
module cgu_cpu_model
(
    input wire logic i_ref_clk,
    input wire logic i_go,
    input wire logic [7:0] i_val,
    output logic o_wr,
    output logic [7:0] o_data
);
    initial
    begin
        o_wr = 1'b0;
        o_data = 8'h00;
    end
    // data scrambled between writes so nothing stale looks valid
    always @(posedge i_ref_clk)
    begin
        o_wr <= i_go;
        o_data <= i_go ? i_val : ~o_data;
    end
endmodule

// [verif/cgu_top_tb.sv]
// cgu_top_tb: directed tests of the clock generation unit
// assumes the design package, interface and checker are compiled first
`timescale 1ns/10ps
module cgu_top_tb;
    logic i_ref_clk = 1'b0;
    logic i_mon_osc = 1'b0;
    logic i_reset_n = 1'b0;
    logic run = 1'b1;
    logic wm = 1'b0, ie = 1'b0, fwr = 1'b0, fwd = 1'b0, men = 1'b0, go = 1'b0;
    logic [2:0] sel = 3'h0, prs = 3'h0, wrs = 3'h0;
    logic [7:0] val = 8'h00;
    logic svc_wr, p, e, fp, fe, pti, irq, wdr, mr, pe_ff, pf_ff, pp_ff;
    logic [7:0] svc_data;
    logic [3:0] ph;
    int cyc = 0, ne = 0, nf = 0, np = 0, wd_n = 0, wd_at = 0, err_count = 0, samples_checked = 0;
    cgu_cpu_model u_cpu (.i_ref_clk(i_ref_clk), .i_go(go), .i_val(val),
        .o_wr(svc_wr), .o_data(svc_data));
    cgu_top u_dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_mon_osc(i_mon_osc),
        .i_wait_mode(wm), .i_slow_divisor_select(sel), .i_periodic_rate_select(prs),
        .i_periodic_irq_enable(ie), .i_periodic_flag_wr(fwr), .i_periodic_flag_wdata(fwd),
        .i_watchdog_rate_select(wrs), .i_monitor_enable_bit(men),
        .i_watchdog_service_wr(svc_wr), .i_watchdog_service_data(svc_data),
        .o_p_clk(p), .o_e_clk(e), .o_fixed_p_clk(fp), .o_fixed_e_clk(fe),
        .o_phase_clk(ph), .o_periodic_timeout_flag(pti), .o_periodic_irq(irq),
        .o_watchdog_reset(wdr), .o_monitor_reset(mr));
    // ==========================================
    // clocks, edge counters, hang limit
    initial forever #2 if (run) i_ref_clk = ~i_ref_clk;
    initial forever #20 i_mon_osc = ~i_mon_osc;
    always @(posedge i_ref_clk)
    begin
        cyc <= cyc + 1;
        pe_ff <= e;
        pf_ff <= fe;
        pp_ff <= p;
        if (e === 1'b1 && pe_ff === 1'b0) ne <= ne + 1;
        if (p === 1'b1 && pp_ff === 1'b0) np <= np + 1;
        if (fe === 1'b1 && pf_ff === 1'b0) nf <= nf + 1;
        if (wdr === 1'b1)
        begin
            wd_n <= wd_n + 1;
            wd_at <= cyc;
        end
        if (cyc == 90000)
        begin
            err_count++;
            stop_test();
        end
    end
    // ==========================================
    // tasks
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic svc(input logic [7:0] v);
        @(posedge i_ref_clk);
        go <= 1'b1;
        val <= v;
        @(posedge i_ref_clk);
        go <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================
    // tests
    initial
    begin : main
        int a, b, f, k, x;
        tick(16);
        chk({ph, pti, irq, wdr, mr}, 8'h10);
        $display("reset test done");
        i_reset_n <= 1'b1;
        men <= 1'b1;
        for (k = 0; k < 9; k++)
        begin
            wm <= (k < 8);
            sel <= (k == 8) ? 3'h3 : k[2:0];
            x = (k % 8 == 0) ? 256 : (256 >> k);
            tick(520);
            a = ne;
            b = np;
            f = nf;
            tick(1024);
            chk(nf - f, 256);
            chk((ne - a) >= x - 1 && (ne - a) <= x + 1, 1);
            chk((np - b) >= 2 * x - 2 && (np - b) <= 2 * x + 2, 1);
            chk(mr, 1'b0);
        end
        $display("slow divider test done");
        wm <= 1'b0;
        sel <= 3'h0;
        for (k = 1; k >= 0; k--)
        begin
            men <= k[0];
            tick(4);
            @(negedge i_ref_clk);
            run = 1'b0;
            #1000;
            chk(mr, k[0]);
            run = 1'b1;
            tick(100);
            chk(mr, 1'b0);
        end
        $display("clock monitor test done");
        wrs <= 3'h2;
        svc(8'h12);
        tick(6);
        chk(wd_n, 1);
        svc(8'haa);
        tick(6);
        chk(wd_n, 1);
        svc(8'h55);
        svc(8'haa);
        a = cyc;
        prs <= 3'h1;
        ie <= 1'b1;
        for (k = 0; k < 32800 && pti !== 1'b1; k++) tick(1);
        chk({pti, irq}, 2'h3);
        fwr <= 1'b1;
        fwd <= 1'b1;
        tick(1);
        fwr <= 1'b0;
        ie <= 1'b0;
        tick(2);
        chk({pti, irq}, 2'h0);
        for (k = 0; k < 70000 && wd_n < 2; k++) tick(1);
        chk(wd_n, 2);
        f = wd_at - a;
        chk(f >= 32760 && f <= 65545, 1);
        $display("watchdog and periodic test done");
        stop_test();
    end
endmodule
